// file: logic/udc_pkg.sv
package udc_pkg;

    // ***********************************
    // Timebase
    // ***********************************
    localparam int CLK_MHZ      = 20;
    localparam int CNT_W        = 21;

    // ***********************************
    // Times as specified
    // ***********************************
    localparam int REJECT_US    = 20;
    localparam int PULSE_MIN_US = 200;
    localparam int SPACING_US   = 10;
    localparam int START_US     = 50;
    localparam int RECALL_MS    = 10;
    localparam int PROG_MS      = 100;
    localparam int STORE_US     = 200;
    localparam int PROP_US      = 65;

    // ***********************************
    // Times in clock cycles
    // ***********************************
    localparam int REJECT_CYC   = REJECT_US * CLK_MHZ;
    localparam int PULSE_CYC    = PULSE_MIN_US * CLK_MHZ;
    localparam int SPACING_CYC  = SPACING_US * CLK_MHZ;
    localparam int START_CYC    = START_US * CLK_MHZ;
    localparam int RECALL_CYC   = RECALL_MS * 1000 * CLK_MHZ;
    localparam int PROG_CYC     = PROG_MS * 1000 * CLK_MHZ;
    localparam int STORE_CYC    = STORE_US * CLK_MHZ;
    localparam int PROP_CYC     = PROP_US * CLK_MHZ;

    // ***********************************
    // Value after reset and code limits
    // ***********************************
    localparam logic [7:0] CODE_RST = 8'h00;
    localparam logic [7:0] CODE_MAX = 8'hff;
    localparam logic [7:0] CODE_MIN = 8'h00;

    typedef logic [CNT_W-1:0] udc_cnt_t;
    typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH, LVL_PROG} udc_level_t;
    typedef enum logic [1:0] {DST_RECALL, DST_RUN, DST_WRITE} udc_dev_state_t;
    typedef enum logic [2:0] {HST_OFF, HST_START, HST_IDLE, HST_PULSE, HST_GAP, HST_PROG,
                              HST_WAIT} udc_host_state_t;

endpackage

// file: logic/udc_link_if.sv
`timescale 1ns/100ps
interface udc_link_if;
    logic count_enable;
    logic ctl_oe;
    logic ctl_val;
    logic ctl_prog;
    logic lvl_hi;
    logic lvl_lo;
    logic lvl_prog;

    // ***********************************
    // Pin level detectors, undriven pin biases to mid
    // ***********************************
    assign lvl_hi   = ctl_oe & (ctl_val | ctl_prog);
    assign lvl_lo   = ctl_oe & ~ctl_val & ~ctl_prog;
    assign lvl_prog = ctl_oe & ctl_prog;

    modport dev  (input count_enable, input lvl_hi, input lvl_lo, input lvl_prog);
    modport host (output count_enable, output ctl_oe, output ctl_val, output ctl_prog);
endinterface

// file: logic/udc_device.sv
// Functional notes
// - Reject pin excursions shorter than 20 us.
// - Controller holds count pulses at least 200 us.
// - Controller spaces count pulses at least 10 us.
// - Controller waits 50 us after enable rise.
// - Enable fall recalls stored code within 10 ms.
// - Nonvolatile write finishes within 100 ms.
// - Programming level held 200 us means store; the device stores on any programming level held 20 us.
// - Tap follows code 65 us after pulse.
// - Code is 8 bits, 0 to 255.
// - Code n selects potentiometer step n+1.
// - Power-up recalls stored code into counter.
// - High pulse decrements, low pulse increments.
// - Counter saturates at both ends.
// - First pulse after enable or write discarded.
// - Changes only while enabled; low reloads code.
`timescale 1ns/100ps
module udc_device
    import udc_pkg::*;
#(
    parameter int RECALL_CYCLES = RECALL_CYC,
    parameter int PROG_CYCLES   = PROG_CYC
) (
    input  wire logic mclk_i,         // 20 MHz clock
    input  wire logic rst_n_i,        // Power-up reset
    udc_link_if.dev   link,           // Control pins
    output logic [7:0] tap_o,         // Potentiometer tap select
    output logic       store_busy_o,  // Nonvolatile write running
    output logic       recall_busy_o  // Recall running
);

    // ***********************************
    // Pin synchronisers
    // ***********************************
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else begin
            sync1_q <= {link.count_enable, link.lvl_prog, link.lvl_hi, link.lvl_lo};
            sync2_q <= sync1_q;
        end
    end

    // ***********************************
    // Level decode and width qualifier
    // ***********************************
    udc_level_t lvl_now;
    udc_level_t lvl_q;
    udc_level_t lvl_d;
    udc_cnt_t   wid_q;
    udc_cnt_t   wid_d;
    logic       ce_q;
    logic       ce_d;
    logic       up_ev;
    logic       dn_ev;
    logic       store_ev;
    logic       qualified;

    always_comb begin
        if (sync2_q[2]) begin
            lvl_now = LVL_PROG;
        end else if (sync2_q[1]) begin
            lvl_now = LVL_HIGH;
        end else if (sync2_q[0]) begin
            lvl_now = LVL_LOW;
        end else begin
            lvl_now = LVL_MID;
        end
        qualified = (wid_q >= CNT_W'(REJECT_CYC));
        lvl_d     = lvl_now;
        ce_d      = sync2_q[3];
        wid_d     = wid_q;
        up_ev     = 1'b0;
        dn_ev     = 1'b0;
        store_ev  = 1'b0;
        if (lvl_now != lvl_q) begin
            wid_d = '0;
            if (lvl_now == LVL_MID && qualified) begin
                up_ev    = (lvl_q == LVL_LOW);
                dn_ev    = (lvl_q == LVL_HIGH);
                store_ev = (lvl_q == LVL_PROG);
            end
        end else if (!qualified) begin
            wid_d = wid_q + CNT_W'(1);
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lvl_q <= LVL_MID;
            wid_q <= '0;
            ce_q  <= 1'b0;
        end else begin
            lvl_q <= lvl_d;
            wid_q <= wid_d;
            ce_q  <= ce_d;
        end
    end

    // ***********************************
    // Code counter and store sequencer
    // ***********************************
    udc_dev_state_t st_q;
    udc_dev_state_t st_d;
    udc_cnt_t       tmr_q;
    udc_cnt_t       tmr_d;
    logic [7:0]     code_q;
    logic [7:0]     code_d;
    bit   [7:0]     nv_q;  // Two-state cell, a blank cell reads as zero
    logic [7:0]     nv_d;
    logic           skip_q;
    logic           skip_d;
    logic           ce_rise;
    logic           ce_fall;

    always_comb begin
        ce_rise = sync2_q[3] & ~ce_q;
        ce_fall = ~sync2_q[3] & ce_q;
        st_d    = st_q;
        tmr_d   = tmr_q + CNT_W'(1);
        code_d  = code_q;
        nv_d    = nv_q;
        skip_d  = skip_q | ce_rise;
        case (st_q)
            DST_RECALL: begin
                if (tmr_q >= CNT_W'(RECALL_CYCLES - 1)) begin
                    code_d = nv_q;
                    st_d   = DST_RUN;
                    tmr_d  = '0;
                end
            end
            DST_RUN: begin
                tmr_d = '0;
                if (ce_fall) begin
                    st_d = DST_RECALL;
                end else if (sync2_q[3] && !ce_rise) begin
                    if (store_ev) begin
                        st_d = DST_WRITE;
                    end else if ((up_ev || dn_ev) && skip_q) begin
                        skip_d = 1'b0;
                    end else if (up_ev && code_q != CODE_MAX) begin
                        code_d = code_q + 8'h01;
                    end else if (dn_ev && code_q != CODE_MIN) begin
                        code_d = code_q - 8'h01;
                    end
                end
            end
            DST_WRITE: begin
                if (tmr_q >= CNT_W'(PROG_CYCLES - 1)) begin
                    nv_d   = code_q;
                    skip_d = 1'b1;
                    st_d   = DST_RUN;
                    tmr_d  = '0;
                end
            end
            default: begin
                st_d  = DST_RECALL;
                tmr_d = '0;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q   <= DST_RECALL;
            tmr_q  <= '0;
            code_q <= CODE_RST;
            skip_q <= 1'b1;
        end else begin
            st_q   <= st_d;
            tmr_q  <= tmr_d;
            code_q <= code_d;
            skip_q <= skip_d;
        end
    end

    // Cell keeps its content across reset
    always_ff @(posedge mclk_i) begin
        nv_q <= nv_d;
    end

    // ***********************************
    // Tap propagation delay
    // ***********************************
    udc_cnt_t   prop_q;
    udc_cnt_t   prop_d;
    logic [7:0] tap_d;
    logic       sbusy_d;
    logic       rbusy_d;

    always_comb begin
        prop_d  = prop_q;
        tap_d   = tap_o;
        sbusy_d = (st_d == DST_WRITE);
        rbusy_d = (st_d == DST_RECALL);
        if (code_d != code_q) begin
            prop_d = CNT_W'(PROP_CYC);
        end else if (prop_q != '0) begin
            prop_d = prop_q - CNT_W'(1);
            if (prop_q == CNT_W'(1)) begin
                tap_d = code_q;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prop_q        <= '0;
            tap_o         <= CODE_RST;
            store_busy_o  <= 1'b0;
            recall_busy_o <= 1'b1;
        end else begin
            prop_q        <= prop_d;
            tap_o         <= tap_d;
            store_busy_o  <= sbusy_d;
            recall_busy_o <= rbusy_d;
        end
    end

endmodule

// file: logic/udc_host.sv
`timescale 1ns/100ps
module udc_host
    import udc_pkg::*;
#(
    parameter int RECALL_CYCLES = RECALL_CYC,
    parameter int PROG_CYCLES   = PROG_CYC
) (
    input  wire logic mclk_i,    // 20 MHz clock
    input  wire logic rst_n_i,   // Asynchronous reset
    udc_link_if.host  link,      // Control pins
    input  wire logic enable_i,  // Request count enable
    input  wire logic up_i,      // Increment request
    input  wire logic down_i,    // Decrement request
    input  wire logic store_i,   // Store request
    output logic      ready_o    // Accepts a request
);

    // ***********************************
    // Pin sequencer
    // ***********************************
    udc_host_state_t st_q;
    udc_host_state_t st_d;
    udc_cnt_t        tmr_q;
    udc_cnt_t        tmr_d;
    logic            ce_d;
    logic            oe_d;
    logic            val_d;
    logic            prog_d;
    logic            rdy_d;
    logic            ce_q;
    logic            oe_q;
    logic            val_q;
    logic            prog_q;

    always_comb begin
        st_d   = st_q;
        tmr_d  = tmr_q + CNT_W'(1);
        ce_d   = ce_q;
        oe_d   = oe_q;
        val_d  = val_q;
        prog_d = prog_q;
        case (st_q)
            HST_OFF: begin
                tmr_d = '0;
                if (enable_i) begin
                    ce_d = 1'b1;
                    st_d = HST_START;
                end
            end
            HST_START: begin
                if (tmr_q >= CNT_W'(START_CYC - 1)) begin
                    st_d = HST_IDLE;
                end
            end
            HST_IDLE: begin
                tmr_d = '0;
                if (!enable_i) begin
                    ce_d = 1'b0;
                    st_d = HST_WAIT;
                end else if (store_i) begin
                    oe_d   = 1'b1;
                    prog_d = 1'b1;
                    st_d   = HST_PROG;
                end else if (up_i || down_i) begin
                    oe_d  = 1'b1;
                    val_d = down_i;
                    st_d  = HST_PULSE;
                end
            end
            HST_PULSE: begin
                if (tmr_q >= CNT_W'(PULSE_CYC - 1)) begin
                    oe_d  = 1'b0;
                    tmr_d = '0;
                    st_d  = HST_GAP;
                end
            end
            HST_GAP: begin
                if (tmr_q >= CNT_W'(SPACING_CYC - 1)) begin
                    st_d = HST_IDLE;
                end
            end
            HST_PROG: begin
                if (tmr_q >= CNT_W'(STORE_CYC - 1)) begin
                    oe_d   = 1'b0;
                    prog_d = 1'b0;
                    tmr_d  = '0;
                    st_d   = HST_WAIT;
                end
            end
            HST_WAIT: begin
                if (tmr_q >= CNT_W'((ce_q ? PROG_CYCLES : RECALL_CYCLES) - 1)) begin
                    st_d = ce_q ? HST_IDLE : HST_OFF;
                end
            end
            default: begin
                st_d = HST_OFF;
            end
        endcase
        rdy_d = (st_d == HST_OFF) || (st_d == HST_IDLE);
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q    <= HST_OFF;
            tmr_q   <= '0;
            ce_q    <= 1'b0;
            oe_q    <= 1'b0;
            val_q   <= 1'b0;
            prog_q  <= 1'b0;
            ready_o <= 1'b1;
        end else begin
            st_q    <= st_d;
            tmr_q   <= tmr_d;
            ce_q    <= ce_d;
            oe_q    <= oe_d;
            val_q   <= val_d;
            prog_q  <= prog_d;
            ready_o <= rdy_d;
        end
    end

    assign link.count_enable = ce_q;
    assign link.ctl_oe       = oe_q;
    assign link.ctl_val      = val_q;
    assign link.ctl_prog     = prog_q;

endmodule

// file: testbench/udc_link_asserts.sv
`timescale 1ns/100ps
module udc_link_asserts
    import udc_pkg::*;
(
    input wire logic mclk_i,        // Clock
    input wire logic rst_n_i,       // Reset, active low
    input wire logic count_enable,  // Count enable pin
    input wire logic ctl_oe,        // Host drives pin
    input wire logic ctl_val,       // Driven level
    input wire logic ctl_prog,      // Programming level
    input wire logic lvl_hi,        // High detector
    input wire logic lvl_lo,        // Low detector
    input wire logic lvl_prog       // Programming detector
);
    // ***********************************
    // Run, gap and enable age counters
    // ***********************************
    udc_cnt_t run_q, run_d;
    udc_cnt_t gap_q, gap_d;
    udc_cnt_t age_q, age_d;

    always_comb begin
        run_d = ctl_oe ? run_q + 1'h1 : '0;
        gap_d = (ctl_oe & ~ctl_prog) ? '0 : gap_q + 1'h1;
        age_d = count_enable ? age_q + 1'h1 : '0;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_q <= '0;
            gap_q <= '0;
            age_q <= '0;
        end else begin
            run_q <= run_d;
            gap_q <= gap_d;
            age_q <= age_d;
        end
    end

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    // ***********************************
    // Properties
    // ***********************************
    property p_pulse_min;
        $fell(ctl_oe) |-> run_q >= PULSE_CYC;
    endproperty
    a_pulse_min: assert property (p_pulse_min) else $error("excursion shorter than minimum");

    property p_gap;
        $rose(ctl_oe) && !ctl_prog |-> gap_q >= SPACING_CYC;
    endproperty
    a_gap: assert property (p_gap) else $error("count pulses too close");

    property p_start;
        $rose(ctl_oe) |-> age_q >= START_CYC;
    endproperty
    a_start: assert property (p_start) else $error("pulse too soon after enable");

    property p_store_len;
        $fell(lvl_prog) |-> run_q == STORE_CYC;
    endproperty
    a_store_len: assert property (p_store_len) else $error("store level length wrong");

    property p_store_release;
        $fell(lvl_prog) |-> !ctl_oe && !lvl_hi && !lvl_lo;
    endproperty
    a_store_release: assert property (p_store_release) else $error("store not ended at mid");

    property p_enable_gate;
        ctl_oe |-> count_enable;
    endproperty
    a_enable_gate: assert property (p_enable_gate) else $error("pin driven while disabled");

    property p_level_stable;
        ctl_oe && $past(ctl_oe) |-> $stable(ctl_val) && $stable(ctl_prog);
    endproperty
    a_level_stable: assert property (p_level_stable) else $error("level changed mid excursion");

    property p_reload_quiet;
        $fell(count_enable) |-> (!ctl_oe)[*8];
    endproperty
    a_reload_quiet: assert property (p_reload_quiet) else $error("pin moved during reload");

    c_low_count: cover property ($fell(lvl_lo));
    c_high_count: cover property ($fell(lvl_hi) && !$past(lvl_prog));
    c_store: cover property ($fell(lvl_prog));
    c_reload: cover property ($fell(count_enable));
endmodule

// file: testbench/updown_code_counter_eeprom_test.sv
`timescale 1ns/100ps
module updown_code_counter_eeprom_test
    import udc_pkg::*;
;
    localparam int RCL      = 50;
    localparam int PRG      = 100;
    localparam int TAP_WAIT = PROP_CYC + 100;

    logic       mclk_i    = 1'h0;
    logic       rst_n_i   = 1'h0;
    logic       enable_i  = 1'h0;
    logic       up_i      = 1'h0;
    logic       down_i    = 1'h0;
    logic       store_i   = 1'h0;
    logic       ready;
    logic [7:0] tap_a;
    logic [7:0] tap_b;
    logic       sbusy_a;
    logic       rbusy_a;
    int         busy_cyc  = 0;
    logic [7:0] exp_code;
    int         failures  = 0;
    int         n_tests   = 0;

    udc_link_if link_a ();
    udc_link_if link_b ();

    always #25 mclk_i = ~mclk_i;

    udc_device #(.RECALL_CYCLES(RCL), .PROG_CYCLES(PRG)) u_udc_device (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .link(link_a),
        .tap_o(tap_a), .store_busy_o(sbusy_a), .recall_busy_o(rbusy_a));
    udc_host #(.RECALL_CYCLES(RCL), .PROG_CYCLES(PRG)) u_udc_host (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .link(link_a), .enable_i(enable_i),
        .up_i(up_i), .down_i(down_i), .store_i(store_i), .ready_o(ready));
    // Second device faced by the bench, for faulty pin traffic
    udc_device #(.RECALL_CYCLES(RCL), .PROG_CYCLES(PRG)) u_udc_device_b (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .link(link_b),
        .tap_o(tap_b), .store_busy_o(), .recall_busy_o());
    udc_link_asserts u_udc_link_asserts (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .count_enable(link_a.count_enable),
        .ctl_oe(link_a.ctl_oe), .ctl_val(link_a.ctl_val), .ctl_prog(link_a.ctl_prog),
        .lvl_hi(link_a.lvl_hi), .lvl_lo(link_a.lvl_lo), .lvl_prog(link_a.lvl_prog));

    always @(posedge mclk_i) if (sbusy_a === 1'h1) busy_cyc <= busy_cyc + 1;

    task close_out;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task wait_ready;
        int i;
        for (i = 0; i < 200000 && ready !== 1'h1; i++) @(negedge mclk_i);
        if (ready !== 1'h1) begin
            failures++;
            close_out();
        end
    endtask

    // One host request, held across the taking edge
    task act(input logic en, input logic up, input logic dn, input logic st);
        @(negedge mclk_i);
        enable_i = en;
        up_i = up;
        down_i = dn;
        store_i = st;
        @(negedge mclk_i);
        up_i = 1'h0;
        down_i = 1'h0;
        store_i = 1'h0;
        @(negedge mclk_i);
        wait_ready();
    endtask

    task pulse(input logic up, input logic [7:0] next);
        act(1'h1, up, ~up, 1'h0);
        check("tap before latency", tap_a, exp_code);
        repeat (TAP_WAIT) @(negedge mclk_i);
        check("tap after pulse", tap_a, next);
        exp_code = next;
    endtask

    task t_count;
        // Power-up code assumed at its reset value
        exp_code = CODE_RST;
        act(1'h1, 1'h0, 1'h0, 1'h0);
        pulse(1'h1, 8'h00);
        pulse(1'h1, 8'h01);
        pulse(1'h1, 8'h02);
        pulse(1'h0, 8'h01);
        pulse(1'h0, 8'h00);
        pulse(1'h0, 8'h00);
        $display("test count done");
    endtask

    task t_store;
        int b0;
        pulse(1'h1, 8'h01);
        b0 = busy_cyc;
        act(1'h1, 1'h0, 1'h0, 1'h1);
        repeat (20) @(negedge mclk_i);
        check("write busy length", {7'h00, ((busy_cyc - b0) inside {[1:PRG]})}, 8'h01);
        check("write finished", {7'h00, sbusy_a}, 8'h00);
        pulse(1'h1, 8'h01);
        pulse(1'h1, 8'h02);
        act(1'h0, 1'h0, 1'h0, 1'h0);
        repeat (20) @(negedge mclk_i);
        check("recall finished", {7'h00, rbusy_a}, 8'h00);
        repeat (TAP_WAIT) @(negedge mclk_i);
        check("tap after reload", tap_a, 8'h01);
        $display("test store done");
    endtask

    task t_power;
        @(negedge mclk_i);
        rst_n_i = 1'h0;
        repeat (10) @(negedge mclk_i);
        rst_n_i = 1'h1;
        repeat (RCL + TAP_WAIT) @(negedge mclk_i);
        check("tap after power-up", tap_a, 8'h01);
        $display("test power done");
    endtask

    // One excursion on the second device's pin, then a gap at mid
    task drive_b(input logic val, input int len);
        link_b.ctl_val = val;
        link_b.ctl_oe = 1'h1;
        repeat (len) @(negedge mclk_i);
        link_b.ctl_oe = 1'h0;
        repeat (SPACING_CYC) @(negedge mclk_i);
    endtask

    // Excursions below the rejection width, both polarities
    task t_glitch;
        int k;
        link_b.count_enable = 1'h1;
        repeat (START_CYC + 100) @(negedge mclk_i);
        drive_b(1'h0, PULSE_CYC);
        drive_b(1'h0, PULSE_CYC);
        repeat (TAP_WAIT) @(negedge mclk_i);
        check("tap after valid pulse", tap_b, 8'h01);
        for (k = 0; k < 2; k++) begin
            drive_b(k[0], REJECT_CYC - 100);
            repeat (TAP_WAIT) @(negedge mclk_i);
            check("tap after short excursion", tap_b, 8'h01);
        end
        $display("test glitch done");
    endtask

    initial begin
        link_b.count_enable = 1'h0;
        link_b.ctl_oe = 1'h0;
        link_b.ctl_val = 1'h0;
        link_b.ctl_prog = 1'h0;
        repeat (10) @(negedge mclk_i);
        rst_n_i = 1'h1;
        repeat (RCL + 10) @(negedge mclk_i);
        t_count();
        t_store();
        t_power();
        t_glitch();
        close_out();
    end

    initial begin
        repeat (90000) @(posedge mclk_i);
        failures++;
        close_out();
    end
endmodule
